// ### wps_cfg.svh
// register indices, field positions, reset values and constants of the wake register bank
`ifndef WPS_CFG_SVH
`define WPS_CFG_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define WPS_IDX_CFG        30'h000004A0
`define WPS_IDX_STAT       30'h000004A1
`define WPS_IDX_DA_HI      30'h000004A2
`define WPS_IDX_DA_MID     30'h000004A3
`define WPS_IDX_DA_LO      30'h000004A4
`define WPS_IDX_PW0        30'h000004A5
`define WPS_IDX_PW1        30'h000004A6
`define WPS_IDX_PW2        30'h000004A7

// ****************************************************************
// wake configuration fields
// ****************************************************************
`define WPS_CFG_SFD_SEL    13
`define WPS_CFG_CRC_GATE   12
`define WPS_CFG_IND_CLR    11
`define WPS_CFG_WAKE_EN    7
`define WPS_CFG_PW_EN      5
`define WPS_CFG_RW_MASK    16'hF7FF

// ****************************************************************
// wake status fields
// ****************************************************************
`define WPS_STAT_SRC       12
`define WPS_STAT_SFD       7
`define WPS_STAT_CRC       6
`define WPS_STAT_PW        5
`define WPS_STAT_PAT       1
`define WPS_STAT_MAG       0

// ****************************************************************
// reset values and delimiter bytes
// ****************************************************************
`define WPS_CFG_RST        16'h1000
`define WPS_STAT_RST       16'h0000
`define WPS_WORD_RST       16'h0000
`define WPS_SFD_ALT        8'h5D
`define WPS_SFD_STD        8'hD5

`endif

// ### wps_pkg.sv
// types shared by the wake register bank modules
package wps_pkg;

	// ****************************************************************
	// types
	// ****************************************************************
	// register bus phase
	typedef enum logic {
		WPS_BUS_IDLE,
		WPS_BUS_ACK
	} wps_bus_type;

	// one register word
	typedef logic [15:0] wps_word_type;

	// six-byte address or password, byte 0 in the low bits
	typedef logic [47:0] wps_six_type;

endpackage

// ### wps_frame_check.sv
// per-frame classification of received packets into wake events
`include "wps_cfg.svh"

module wps_frame_check
	import wps_pkg::*;
(
	// clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	// frame summary from the receive datapath
	input  wire logic            frame_done_i,
	input  wire logic [7:0]      sfd_byte_i,
	input  wire logic            crc_ok_i,
	input  wire logic            magic_seen_i,
	input  wire logic            pattern_seen_i,
	input  wire wps_pkg::wps_six_type dest_addr_i,
	input  wire wps_pkg::wps_six_type rx_password_i,
	// configuration
	input  wire logic            sfd_sel_i,
	input  wire logic            crc_gate_i,
	input  wire logic            pw_en_i,
	input  wire wps_pkg::wps_six_type match_addr_i,
	input  wire wps_pkg::wps_six_type match_password_i,
	// one-cycle event pulses
	output logic                 evt_sfd_o,
	output logic                 evt_crc_o,
	output logic                 evt_pw_o,
	output logic                 evt_pat_o,
	output logic                 evt_mag_o
);
	import wps_pkg::*;

	logic       sfd_bad;   // delimiter byte missing
	logic       crc_bad;   // frame check sequence wrong
	logic       addr_ok;   // destination perfect match
	logic       pw_bad;    // password differs
	logic [4:0] nxt_evt;   // next event pulses
	logic [4:0] evt_ff;    // registered event pulses

	// ****************************************************************
	// classification
	// ****************************************************************
	// evaluate a finished frame
	always_comb begin
		sfd_bad = sfd_byte_i != (sfd_sel_i ? `WPS_SFD_ALT : `WPS_SFD_STD);
		crc_bad = ~crc_ok_i;
		addr_ok = dest_addr_i == match_addr_i;
		pw_bad = pw_en_i & (rx_password_i != match_password_i);
		nxt_evt = 5'h00;
		if (frame_done_i) begin
			if (sfd_bad) begin
				nxt_evt[4] = 1'b1;
			end else if (crc_bad) begin
				// bad frame check, silent when gate off
				nxt_evt[3] = crc_gate_i;
			end else if (addr_ok) begin
				nxt_evt[2] = magic_seen_i & pw_bad;
				nxt_evt[0] = magic_seen_i & ~pw_bad;
				nxt_evt[1] = pattern_seen_i;
			end
		end
	end

	// register the pulses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_ff <= 5'h00;
		end else begin
			evt_ff <= nxt_evt;
		end
	end

	assign evt_sfd_o = evt_ff[4];
	assign evt_crc_o = evt_ff[3];
	assign evt_pw_o  = evt_ff[2];
	assign evt_pat_o = evt_ff[1];
	assign evt_mag_o = evt_ff[0];

endmodule

// ### wps_regs.sv
// wake status, match address and password register bank on classic wishbone
`include "wps_cfg.svh"

module wps_regs
	import wps_pkg::*;
(
	// clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	// wishbone slave
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [31:0]     wb_adr_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic [31:0]     wb_dat_i,
	output logic      [31:0]     wb_dat_o,
	output logic                 wb_ack_o,
	// frame summary from the receive datapath
	input  wire logic            frame_done_i,
	input  wire logic [7:0]      sfd_byte_i,
	input  wire logic            crc_ok_i,
	input  wire logic            magic_seen_i,
	input  wire logic            pattern_seen_i,
	input  wire wps_pkg::wps_six_type dest_addr_i,
	input  wire wps_pkg::wps_six_type rx_password_i,
	// other interrupt source and shared interrupt bit
	input  wire logic            polarity_event_i,
	output logic                 shared_int_o,
	// wake state for the rest of the device
	output logic                 wake_enabled_o,
	output logic                 ind_clear_o
);
	import wps_pkg::*;

	// ****************************************************************
	// functions
	// ****************************************************************
	// true when the byte address hits a register index
	function automatic logic wps_hit(input logic [31:0] adr, input logic [29:0] idx);
		wps_hit = (adr[31:2] == idx) && (adr[1:0] == 2'b00);
	endfunction

	// swap the two bytes of a word
	function automatic logic [15:0] wps_swap(input logic [15:0] w);
		wps_swap = {w[7:0], w[15:8]};
	endfunction

	// byte-lane write merge on the low two lanes
	function automatic logic [15:0] wps_merge(input logic [15:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		wps_merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
	endfunction

	// ****************************************************************
	// declarations
	// ****************************************************************
	wps_bus_type  bus_ff;          // bus phase
	wps_bus_type  nxt_bus;         // next bus phase
	logic [31:0]  rdat_ff;         // registered read data
	logic [31:0]  nxt_rdat;        // next read data
	logic [31:0]  rd_word;         // read mux output
	logic         req;             // request present
	logic         wr_go;           // write takes effect now
	logic         rd_clr;          // status read completes now

	wps_word_type cfg_ff;          // wake configuration
	wps_word_type nxt_cfg;
	logic         ind_clr_ff;      // one-cycle level clear strobe
	logic         nxt_ind_clr;
	logic         src_ff;          // interrupt source select
	logic         nxt_src;
	logic [4:0]   flag_ff;         // sfd, crc, pw, pat, mag
	logic [4:0]   nxt_flag;
	logic [4:0]   flag_set;        // gated events this cycle
	logic [4:0]   flag_clr;        // bits that were read out
	wps_word_type da_hi_ff;        // address bytes 4 and 5
	wps_word_type da_mid_ff;       // address bytes 2 and 3
	wps_word_type da_lo_ff;        // address bytes 0 and 1
	wps_word_type pw0_ff;          // password bytes 1 and 0
	wps_word_type pw1_ff;          // password bytes 3 and 2
	wps_word_type pw2_ff;          // password bytes 5 and 4
	wps_word_type nxt_da_hi;
	wps_word_type nxt_da_mid;
	wps_word_type nxt_da_lo;
	wps_word_type nxt_pw0;
	wps_word_type nxt_pw1;
	wps_word_type nxt_pw2;
	wps_six_type  match_addr;      // address, byte 0 low
	wps_six_type  match_pw;        // password, byte 0 low
	logic         int_ff;          // shared interrupt pulse
	logic         nxt_int;
	logic         evt_sfd;         // raw frame events
	logic         evt_crc;
	logic         evt_pw;
	logic         evt_pat;
	logic         evt_mag;

	// ****************************************************************
	// wishbone slave
	// ****************************************************************
	assign req = wb_cyc_i & wb_stb_i;

	// read mux, reserved and unmapped read zero
	always_comb begin
		rd_word = 32'h00000000;
		if (wps_hit(wb_adr_i, `WPS_IDX_CFG)) begin
			rd_word[15:0] = cfg_ff & `WPS_CFG_RW_MASK;
		end else if (wps_hit(wb_adr_i, `WPS_IDX_STAT)) begin
			rd_word[`WPS_STAT_SRC] = src_ff;
			rd_word[`WPS_STAT_SFD] = flag_ff[4];
			rd_word[`WPS_STAT_CRC] = flag_ff[3];
			rd_word[`WPS_STAT_PW]  = flag_ff[2];
			rd_word[`WPS_STAT_PAT] = flag_ff[1];
			rd_word[`WPS_STAT_MAG] = flag_ff[0];
		end else if (wps_hit(wb_adr_i, `WPS_IDX_DA_HI)) begin
			rd_word[15:0] = da_hi_ff;
		end else if (wps_hit(wb_adr_i, `WPS_IDX_DA_MID)) begin
			rd_word[15:0] = da_mid_ff;
		end else if (wps_hit(wb_adr_i, `WPS_IDX_DA_LO)) begin
			rd_word[15:0] = da_lo_ff;
		end else if (wps_hit(wb_adr_i, `WPS_IDX_PW0)) begin
			rd_word[15:0] = pw0_ff;
		end else if (wps_hit(wb_adr_i, `WPS_IDX_PW1)) begin
			rd_word[15:0] = pw1_ff;
		end else if (wps_hit(wb_adr_i, `WPS_IDX_PW2)) begin
			rd_word[15:0] = pw2_ff;
		end
	end

	// bus phase: take in idle, answer one cycle later
	always_comb begin
		nxt_bus  = bus_ff;
		nxt_rdat = rdat_ff;
		wr_go    = 1'b0;
		rd_clr   = 1'b0;
		case (bus_ff)
			WPS_BUS_IDLE: begin
				// capture read data with the request
				if (req) begin
					nxt_bus  = WPS_BUS_ACK;
					nxt_rdat = wb_we_i ? 32'h00000000 : rd_word;
				end
			end
			WPS_BUS_ACK: begin
				// ack edge: write lands, read clears
				nxt_bus = WPS_BUS_IDLE;
				wr_go   = req & wb_we_i;
				rd_clr  = req & ~wb_we_i & wps_hit(wb_adr_i, `WPS_IDX_STAT);
			end
			default: begin
				nxt_bus = WPS_BUS_IDLE;
			end
		endcase
	end

	// bus state registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_ff  <= WPS_BUS_IDLE;
			rdat_ff <= 32'h00000000;
		end else begin
			bus_ff  <= nxt_bus;
			rdat_ff <= nxt_rdat;
		end
	end

	assign wb_ack_o = (bus_ff == WPS_BUS_ACK) & req;
	assign wb_dat_o = rdat_ff;

	// ****************************************************************
	// configuration, address and password words
	// ****************************************************************
	// next values of the plain read-write words
	always_comb begin
		nxt_cfg     = cfg_ff;
		nxt_ind_clr = 1'b0;
		nxt_da_hi   = da_hi_ff;
		nxt_da_mid  = da_mid_ff;
		nxt_da_lo   = da_lo_ff;
		nxt_pw0     = pw0_ff;
		nxt_pw1     = pw1_ff;
		nxt_pw2     = pw2_ff;
		if (wr_go) begin
			// wake configuration, clear bit self-clears
			if (wps_hit(wb_adr_i, `WPS_IDX_CFG)) begin
				nxt_cfg     = wps_merge(cfg_ff, wb_dat_i, wb_sel_i) & `WPS_CFG_RW_MASK;
				nxt_ind_clr = wb_sel_i[1] & wb_dat_i[`WPS_CFG_IND_CLR];
			end
			if (wps_hit(wb_adr_i, `WPS_IDX_DA_HI)) begin
				nxt_da_hi = wps_merge(da_hi_ff, wb_dat_i, wb_sel_i);
			end
			if (wps_hit(wb_adr_i, `WPS_IDX_DA_MID)) begin
				nxt_da_mid = wps_merge(da_mid_ff, wb_dat_i, wb_sel_i);
			end
			if (wps_hit(wb_adr_i, `WPS_IDX_DA_LO)) begin
				nxt_da_lo = wps_merge(da_lo_ff, wb_dat_i, wb_sel_i);
			end
			if (wps_hit(wb_adr_i, `WPS_IDX_PW0)) begin
				nxt_pw0 = wps_merge(pw0_ff, wb_dat_i, wb_sel_i);
			end
			if (wps_hit(wb_adr_i, `WPS_IDX_PW1)) begin
				nxt_pw1 = wps_merge(pw1_ff, wb_dat_i, wb_sel_i);
			end
			if (wps_hit(wb_adr_i, `WPS_IDX_PW2)) begin
				nxt_pw2 = wps_merge(pw2_ff, wb_dat_i, wb_sel_i);
			end
		end
	end

	// word registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_ff     <= `WPS_CFG_RST;
			ind_clr_ff <= 1'b0;
			da_hi_ff   <= `WPS_WORD_RST;
			da_mid_ff  <= `WPS_WORD_RST;
			da_lo_ff   <= `WPS_WORD_RST;
			pw0_ff     <= `WPS_WORD_RST;
			pw1_ff     <= `WPS_WORD_RST;
			pw2_ff     <= `WPS_WORD_RST;
		end else begin
			cfg_ff     <= nxt_cfg;
			ind_clr_ff <= nxt_ind_clr;
			da_hi_ff   <= nxt_da_hi;
			da_mid_ff  <= nxt_da_mid;
			da_lo_ff   <= nxt_da_lo;
			pw0_ff     <= nxt_pw0;
			pw1_ff     <= nxt_pw1;
			pw2_ff     <= nxt_pw2;
		end
	end

	// address bytes packed byte 0 lowest, halves swapped
	assign match_addr = {wps_swap(da_hi_ff), wps_swap(da_mid_ff), wps_swap(da_lo_ff)};
	// password bytes already low byte first
	assign match_pw   = {pw2_ff, pw1_ff, pw0_ff};

	assign wake_enabled_o = cfg_ff[`WPS_CFG_WAKE_EN];
	assign ind_clear_o    = ind_clr_ff;

	// ****************************************************************
	// frame classification
	// ****************************************************************
	wps_frame_check u_check (
		.clk_i            (clk_i),
		.rst_i            (rst_i),
		.frame_done_i     (frame_done_i),
		.sfd_byte_i       (sfd_byte_i),
		.crc_ok_i         (crc_ok_i),
		.magic_seen_i     (magic_seen_i),
		.pattern_seen_i   (pattern_seen_i),
		.dest_addr_i      (dest_addr_i),
		.rx_password_i    (rx_password_i),
		.sfd_sel_i        (cfg_ff[`WPS_CFG_SFD_SEL]),
		.crc_gate_i       (cfg_ff[`WPS_CFG_CRC_GATE]),
		.pw_en_i          (cfg_ff[`WPS_CFG_PW_EN]),
		.match_addr_i     (match_addr),
		.match_password_i (match_pw),
		.evt_sfd_o        (evt_sfd),
		.evt_crc_o        (evt_crc),
		.evt_pw_o         (evt_pw),
		.evt_pat_o        (evt_pat),
		.evt_mag_o        (evt_mag)
	);

	// ****************************************************************
	// status flags and interrupt source
	// ****************************************************************
	// sticky flags with read-clear and source select
	always_comb begin
		// events count only while wake is enabled
		flag_set = cfg_ff[`WPS_CFG_WAKE_EN] ?
			{evt_sfd, evt_crc, evt_pw, evt_pat, evt_mag} : 5'h00;
		// only bits returned by the read are cleared
		flag_clr = rd_clr ? {rdat_ff[`WPS_STAT_SFD], rdat_ff[`WPS_STAT_CRC],
			rdat_ff[`WPS_STAT_PW], rdat_ff[`WPS_STAT_PAT], rdat_ff[`WPS_STAT_MAG]} : 5'h00;
		// latch and read-clear, set beats clear
		// same latch for bad frame check
		// a coinciding event survives the read
		nxt_flag = (flag_ff & ~flag_clr) | flag_set;
		nxt_src  = src_ff;
		// software write of the source select
		if (wr_go && wps_hit(wb_adr_i, `WPS_IDX_STAT) && wb_sel_i[1]) begin
			nxt_src = wb_dat_i[`WPS_STAT_SRC];
		end
		if (~cfg_ff[`WPS_CFG_WAKE_EN] & nxt_cfg[`WPS_CFG_WAKE_EN]) begin
			nxt_src = 1'b1;
		end
		// route wake or polarity event to shared bit
		nxt_int = src_ff ? (|flag_set) : polarity_event_i;
	end

	// flag registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// all status bits reset to zero
			flag_ff <= 5'h00;
			src_ff  <= 1'b0;
			int_ff  <= 1'b0;
		end else begin
			flag_ff <= nxt_flag;
			src_ff  <= nxt_src;
			int_ff  <= nxt_int;
		end
	end

	assign shared_int_o = int_ff;

endmodule

// ### wps_regs_props.sv
// assertion checker for the wake register bank ports
`include "wps_cfg.svh"

module wps_regs_props
	import wps_pkg::*;
(
	// clock, reset and register bus
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire logic                 wb_cyc_i,
	input wire logic                 wb_stb_i,
	input wire logic                 wb_we_i,
	input wire logic [31:0]          wb_adr_i,
	input wire logic [3:0]           wb_sel_i,
	input wire logic [31:0]          wb_dat_i,
	input wire logic [31:0]          wb_dat_o,
	input wire logic                 wb_ack_o,
	// frame summary and event side
	input wire logic                 frame_done_i,
	input wire logic [7:0]           sfd_byte_i,
	input wire logic                 crc_ok_i,
	input wire logic                 magic_seen_i,
	input wire logic                 pattern_seen_i,
	input wire wps_pkg::wps_six_type dest_addr_i,
	input wire wps_pkg::wps_six_type rx_password_i,
	input wire logic                 polarity_event_i,
	input wire logic                 shared_int_o,
	input wire logic                 wake_enabled_o,
	input wire logic                 ind_clear_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************
	// shadow of configuration and source select
	// ****************
	logic [15:0] cfg_ff;  // configuration copy
	logic [15:0] nxt_cfg;
	logic        src_ff;  // source select copy
	logic        nxt_src;
	logic        wr_cfg;  // write to configuration lands
	logic        wr_st;   // write to status lands
	logic [7:0]  sfd_exp; // delimiter searched for

	assign wr_cfg = wb_ack_o && wb_we_i && wb_adr_i == {`WPS_IDX_CFG, 2'b00};
	assign wr_st = wb_ack_o && wb_we_i && wb_adr_i == {`WPS_IDX_STAT, 2'b00};
	assign sfd_exp = cfg_ff[`WPS_CFG_SFD_SEL] ? `WPS_SFD_ALT : `WPS_SFD_STD;

	// next shadow values, enabling wins over status write
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_src = src_ff;
		if (wr_st && wb_sel_i[1]) begin
			nxt_src = wb_dat_i[`WPS_STAT_SRC];
		end
		if (wr_cfg && wb_sel_i[0]) begin
			nxt_cfg[7:0] = wb_dat_i[7:0];
			nxt_src = nxt_src | (wb_dat_i[7] & ~cfg_ff[7]);
		end
		if (wr_cfg && wb_sel_i[1]) begin
			nxt_cfg[15:8] = wb_dat_i[15:8];
		end
	end

	// shadow registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_ff <= `WPS_CFG_RST;
			src_ff <= 1'b0;
		end else begin
			cfg_ff <= nxt_cfg;
			src_ff <= nxt_src;
		end
	end

	// ****************
	// assertions
	// ****************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// frame taken while detection runs and wake feeds the shared bit
	sequence s_frame;
		frame_done_i && wake_enabled_o && src_ff;
	endsequence
	// same frame with the right delimiter
	sequence s_good;
		s_frame ##0 sfd_byte_i == sfd_exp;
	endsequence

	a_enable_mirror: assert property (wake_enabled_o == cfg_ff[`WPS_CFG_WAKE_EN])
		else $error("wake enable output differs from configuration");
	a_polarity_route: assert property (polarity_event_i && !src_ff |=> shared_int_o)
		else $error("polarity event not routed to shared bit");
	// classifier register, then flag and pulse register: two edges
	a_int_cause: assert property (shared_int_o |-> $past(polarity_event_i) || $past(frame_done_i, 2))
		else $error("shared bit pulse without a cause");
	a_sfd_event: assert property (s_frame ##0 sfd_byte_i != sfd_exp |-> ##2 shared_int_o)
		else $error("delimiter error gave no wake pulse");
	a_crc_gated: assert property (s_good ##0 !crc_ok_i && cfg_ff[12] |-> ##2 shared_int_o)
		else $error("bad frame check gave no wake pulse");
	a_crc_silent: assert property (s_good ##0 !crc_ok_i && !cfg_ff[12] |-> ##2 !shared_int_o)
		else $error("bad frame check indicated with gate off");
	a_idle_quiet: assert property (frame_done_i && !wake_enabled_o && src_ff |-> ##2 !shared_int_o)
		else $error("wake pulse while detection disabled");
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged in next cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	a_status_rsvd: assert property (wb_ack_o && !wb_we_i && wb_adr_i == {`WPS_IDX_STAT, 2'b00}
		|-> (wb_dat_o & 32'hFFFFEF1C) == 32'h00000000 && wb_dat_o[12] == src_ff)
		else $error("status read shows reserved bits or wrong source");
endmodule

bind wps_regs wps_regs_props i_props (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_done_i(frame_done_i),
	.sfd_byte_i(sfd_byte_i), .crc_ok_i(crc_ok_i), .magic_seen_i(magic_seen_i),
	.pattern_seen_i(pattern_seen_i), .dest_addr_i(dest_addr_i),
	.rx_password_i(rx_password_i), .polarity_event_i(polarity_event_i),
	.shared_int_o(shared_int_o), .wake_enabled_o(wake_enabled_o), .ind_clear_o(ind_clear_o)
);

// ### wps_regs_tb.sv
// self-checking bench for the wake register bank
`include "wps_cfg.svh"

`define CHK(a, e) begin \
	n_checks++; \
	if ((a) !== (e)) begin \
		err_total++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); \
	end \
end

module wps_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import wps_pkg::*;

	// ****************
	// stimulus and observed signals
	// ****************
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [31:0] adr = '0, wdat = '0, rdat;
	logic [3:0]  sel = '0;
	logic        ack, shint, wken, indc;
	logic        fd = 1'b0, crc = 1'b0, mag = 1'b0, pat = 1'b0, pol = 1'b0;
	logic [7:0]  sfd = '0;
	wps_six_type dest = '0, rpw = '0, da, pw;
	logic [15:0] q, c, w [6];      // read word, configuration, stored words
	int          seed = 15683;
	int          err_total = 0, n_checks = 0, cyc_n = 0;
	logic [31:0] r;
	logic [7:0]  sb;               // delimiter byte driven on the pin, random or one of the two delimiters
	logic [15:0] ex;               // expected status word

	wps_regs i_wps_regs (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.frame_done_i(fd), .sfd_byte_i(sfd), .crc_ok_i(crc), .magic_seen_i(mag),
		.pattern_seen_i(pat), .dest_addr_i(dest), .rx_password_i(rpw),
		.polarity_event_i(pol), .shared_int_o(shint), .wake_enabled_o(wken),
		.ind_clear_o(indc)
	);

	// 50 MHz clock
	initial begin
		forever #10 clk_i = ~clk_i;
	end

	// verdict and end of run
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			err_total++;
			summarize();
		end
	end

	// one classic bus cycle, held until acknowledge
	task automatic wb(input logic wr, input logic [29:0] ix, input logic [15:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= {ix, 2'b00};
		sel <= 4'h3;
		wdat <= {16'h0000, d};
		// acknowledge ends this wait, else the hang guard ends the run
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	// read and compare one word
	task automatic rd(input logic [29:0] ix, input logic [15:0] e);
		wb(1'b0, ix, 16'h0000);
		`CHK(q, e)
	endtask

	// one received frame summary
	task automatic frame(input logic [7:0] s, input logic ok, m, p, dm, pm);
		@(posedge clk_i);
		fd <= 1'b1;
		sfd <= s;
		crc <= ok;
		mag <= m;
		pat <= p;
		dest <= dm ? da : ~da;
		rpw <= pm ? pw : pw ^ 48'h000000000001;
		@(posedge clk_i);
		fd <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask

	// expected status word after one frame
	function automatic logic [15:0] expf(logic [15:0] cf, logic [7:0] s,
		logic ok, m, p, dm, pm);
		logic [15:0] f;
		f = 16'h1000;
		if (!cf[7]) return f;
		if (s !== (cf[13] ? `WPS_SFD_ALT : `WPS_SFD_STD)) begin
			f[7] = 1'b1;
		end else if (!ok) begin
			f[6] = cf[12];
		end else if (dm) begin
			f[5] = m && cf[5] && !pm;
			f[0] = m && !(cf[5] && !pm);
			f[1] = p;
		end
		return f;
	endfunction

	initial begin
		da = 48'({$random(seed), $random(seed)});
		pw = 48'({$random(seed), $random(seed)});
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			rd(`WPS_IDX_CFG + 30'(i), i == 0 ? `WPS_CFG_RST : 16'h0000);
		end
		$display("test reset values done");
		w[0] = {da[39:32], da[47:40]};
		w[1] = {da[23:16], da[31:24]};
		w[2] = {da[7:0], da[15:8]};
		w[3] = pw[15:0];
		w[4] = pw[31:16];
		w[5] = pw[47:32];
		for (int i = 0; i < 6; i++) wb(1'b1, `WPS_IDX_DA_HI + 30'(i), w[i]);
		for (int i = 0; i < 6; i++) rd(`WPS_IDX_DA_HI + 30'(i), w[i]);
		wb(1'b1, 30'h000004AC, 16'hFFFF);
		rd(30'h000004AC, 16'h0000);
		wb(1'b1, `WPS_IDX_STAT, 16'hFFFF);
		rd(`WPS_IDX_STAT, 16'h1000);
		$display("test read write done");
		wb(1'b1, `WPS_IDX_STAT, 16'h0000);
		@(posedge clk_i);
		pol <= 1'b1;
		@(posedge clk_i);
		pol <= 1'b0;
		@(negedge clk_i);
		`CHK(shint, 1'b1)
		wb(1'b1, `WPS_IDX_CFG, 16'h1080);
		rd(`WPS_IDX_STAT, 16'h1000);
		`CHK(wken, 1'b1)
		// level clear strobe pulses once, bit reads back zero
		wb(1'b1, `WPS_IDX_CFG, 16'h1880);
		@(negedge clk_i);
		`CHK(indc, 1'b1)
		rd(`WPS_IDX_CFG, 16'h1080);
		`CHK(indc, 1'b0)
		$display("test source select done");
		for (int k = 0; k < 64; k++) begin
			r = $random(seed);
			c = r[31:16] & 16'h30A0;
			c[7] = (k % 4) != 0;
			sb = r[1:0] == 2'b00 ? r[15:8] : (r[2] ? `WPS_SFD_ALT : `WPS_SFD_STD);
			ex = expf(c, sb, r[3] | r[4], r[5], r[6] & r[7], r[7] | r[8], r[9]);
			wb(1'b1, `WPS_IDX_CFG, c);
			frame(sb, r[3] | r[4], r[5], r[6] & r[7], r[7] | r[8], r[9]);
			rd(`WPS_IDX_STAT, ex);
			rd(`WPS_IDX_STAT, 16'h1000);
		end
		$display("test frame events done");
		wb(1'b1, `WPS_IDX_CFG, 16'h1080);
		frame(`WPS_SFD_STD, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
		fork
			rd(`WPS_IDX_STAT, 16'h1001);
			frame(`WPS_SFD_STD, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
		join
		rd(`WPS_IDX_STAT, 16'h1001);
		rd(`WPS_IDX_STAT, 16'h1000);
		$display("test read collision done");
		summarize();
	end
endmodule
